// ### verilog/bc_seq_pkg.sv
// constants, state codes and field layout shared by the message block sequencer
package bc_seq_pkg;
	localparam int WORD_W      = 16;
	localparam int ADDR_W      = 16;
	localparam int FIFO_DEPTH  = 8;
	localparam int CNT_W       = 6;

	// command word fields
	localparam int CMD_RT_MSB  = 15;
	localparam int CMD_RT_LSB  = 11;
	localparam int CMD_TR_BIT  = 10;
	localparam int CMD_SA_MSB  = 9;
	localparam int CMD_SA_LSB  = 5;
	localparam int CMD_WC_MSB  = 4;
	localparam int CMD_WC_LSB  = 0;
	localparam int MODE_DATA_BIT = 4;

	// status word fields
	localparam int STS_RT_MSB  = 15;
	localparam int STS_RT_LSB  = 11;
	localparam int STS_ME_BIT  = 10;
	localparam int STS_IN_BIT  = 9;
	localparam int STS_SR_BIT  = 8;
	localparam int STS_RSV_MSB = 7;
	localparam int STS_RSV_LSB = 5;
	localparam int STS_BC_BIT  = 4;
	localparam int STS_BY_BIT  = 3;
	localparam int STS_SF_BIT  = 2;
	localparam int STS_DB_BIT  = 1;
	localparam int STS_TF_BIT  = 0;

	// control word fields
	localparam int CTL_BUS_A_BIT  = 7;
	localparam int CTL_TEST_BIT   = 6;
	localparam int CTL_MBC_BIT    = 5;
	localparam int CTL_MODE_BIT   = 2;
	localparam int CTL_BCAST_BIT  = 1;
	localparam int CTL_RTRT_BIT   = 0;
	localparam logic [WORD_W-1:0] CTL_LEGACY_MASK = 16'h00e7;

	// block offsets and reset values
	localparam logic [ADDR_W-1:0] OFS_CTRL = 16'h0000;
	localparam logic [ADDR_W-1:0] OFS_CMD1 = 16'h0001;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_RST  = 6'h00;
	localparam logic [CNT_W-1:0]  WC_FULL  = 6'h20;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_RD_CTRL   = 4'h1,
		ST_RD_CMD1   = 4'h2,
		ST_RD_CMD2   = 4'h3,
		ST_SEND_CMD1 = 4'h4,
		ST_SEND_CMD2 = 4'h5,
		ST_RD_DATA   = 4'h6,
		ST_SEND_DATA = 4'h7,
		ST_TAKE_RX   = 4'h8,
		ST_WR_RX     = 4'h9,
		ST_DONE      = 4'ha
	} seq_state_type;
endpackage : bc_seq_pkg

// ### verilog/word_stream_if.sv
// valid/ready word stream between the sequencer and its receive buffer
interface word_stream_if #(parameter int W = 16) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface : word_stream_if

// ### verilog/word_fifo.sv
// flip-flop fifo for received bus words
module word_fifo
	import bc_seq_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic   clock,
	input  wire logic   rst_n,
	input  wire logic   en,
	word_stream_if.sink   in_s,
	word_stream_if.source out_s
);
	localparam int PW = $clog2(DEPTH);

	// pointer arithmetic relies on wrap at a power of two
	if (DEPTH < 2 || (1 << PW) != DEPTH)
		$error("word_fifo: DEPTH must be a power of two, at least 2");

	logic [WIDTH-1:0] mem_reg  [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW:0]      wr_reg, wr_next, rd_reg, rd_next;
	logic             full, empty, push, pop;

	// extra pointer bit tells full from empty
	assign empty       = (wr_reg == rd_reg);
	assign full        = (wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]);
	assign in_s.ready  = en && !full;
	assign out_s.valid = en && !empty;
	assign out_s.data  = mem_reg[rd_reg[PW-1:0]];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	// next storage and pointers
	always_comb
	begin
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
		for (int i = 0; i < DEPTH; i++)
		begin
			mem_next[i] = mem_reg[i];
			if (push && wr_reg[PW-1:0] == PW'(i))
				mem_next[i] = in_s.data;
		end
	end

	// storage needs no reset, pointers do
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else if (en)
		begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
		if (en)
			mem_reg <= mem_next;
	end
endmodule : word_fifo

// ### verilog/bc_message_block_sequencer.sv
// legacy controller message block sequencer: fetch, send, store per message format
// How it works
// - every standard transfer format is sequenced, normal and broadcast variants
// - word order of a block is chosen from control word format bits, command bit 10 and, for mode commands, bit 4
// - control, commands and transmit data are fetched in block order
// - received words are written to the next contiguous block locations
// - offset zero of every block is taken as the control word
// - command bits 15..11 hold terminal address, bit 10 transmit/receive
// - command bits 9..5 hold subaddress or mode indicator, bit 9 msb
// - command bits 4..0 hold word count or mode code, bit 0 lsb
// - status bits 15..11 address, 10 message error, 9 instr, 8 service
// - status 7..5 reserved, 4 broadcast, 3 busy, 2 subsys, 1 dynbus, 0 flag
// - terminal-to-controller: ctrl, tx command, loopback, status, data in order
// - control word is never sent on the bus
// - without expanded option only control bits 7,6,5,2,1,0 are kept
module bc_message_block_sequencer
	import bc_seq_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              en,
	input  wire logic              expanded_ctrl,
	input  wire logic              start,
	input  wire logic [ADDR_W-1:0] block_addr,
	output logic                   busy,
	output logic                   done,
	output logic                   mem_req,
	output logic                   mem_we,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic      [WORD_W-1:0] mem_wdata,
	input  wire logic              mem_ack,
	input  wire logic [WORD_W-1:0] mem_rdata,
	output logic                   tx_valid,
	input  wire logic              tx_ready,
	output logic      [WORD_W-1:0] tx_data,
	output logic                   tx_is_cmd,
	input  wire logic              rx_valid,
	output logic                   rx_ready,
	input  wire logic [WORD_W-1:0] rx_data,
	output logic                   ctrl_bus_a,
	output logic                   ctrl_self_test,
	output logic                   ctrl_mask_bcast,
	output logic      [4:0]        cmd_rt_addr,
	output logic                   cmd_tr,
	output logic      [4:0]        cmd_subaddr,
	output logic      [4:0]        cmd_count,
	output logic      [4:0]        sts_rt_addr,
	output logic                   sts_msg_error,
	output logic                   sts_instr,
	output logic                   sts_srv_req,
	output logic      [2:0]        sts_reserved,
	output logic                   sts_bcast_rcvd,
	output logic                   sts_busy,
	output logic                   sts_subsys_flag,
	output logic                   sts_dyn_bus_acc,
	output logic                   sts_term_flag
);
	// data word count, zero meaning thirty-two
	function automatic logic [CNT_W-1:0] word_count(input logic [WORD_W-1:0] c);
		return (c[CMD_WC_MSB:CMD_WC_LSB] == 5'h00) ? WC_FULL : {1'b0, c[CMD_WC_MSB:CMD_WC_LSB]};
	endfunction : word_count

	// {transmit data words, received words} for a format
	function automatic logic [2*CNT_W-1:0] plan(input logic [WORD_W-1:0] ctl,
		input logic [WORD_W-1:0] cmd);
		logic [CNT_W-1:0] wc, ntx, nrx;
		logic             tr, bc, md;
		wc  = word_count(cmd);
		tr  = cmd[CMD_TR_BIT];
		bc  = ctl[CTL_BCAST_BIT];
		md  = cmd[MODE_DATA_BIT];
		ntx = CNT_RST;
		nrx = CNT_RST;
		if (ctl[CTL_MODE_BIT])
		begin
			ntx = (md && !tr) ? 6'h01 : 6'h00;
			nrx = bc ? 6'h01 : ((md && tr) ? 6'h03 : 6'h02);
		end
		else if (ctl[CTL_RTRT_BIT])
			nrx = bc ? wc + 6'h02 : wc + 6'h03;
		else if (tr)
			nrx = wc + 6'h02;
		else
		begin
			ntx = wc;
			nrx = bc ? 6'h01 : 6'h02;
		end
		return {ntx, nrx};
	endfunction : plan

	// is received word number idx an rt status word
	function automatic logic is_status(input logic [WORD_W-1:0] ctl,
		input logic [CNT_W-1:0] idx, input logic [CNT_W-1:0] nrx);
		logic first, last;
		first = (idx == 6'h01) && (!ctl[CTL_BCAST_BIT] || ctl[CTL_RTRT_BIT]);
		last  = ctl[CTL_RTRT_BIT] && !ctl[CTL_BCAST_BIT] && (idx == nrx - 6'h01);
		return first || last;
	endfunction : is_status

	seq_state_type     state_reg, state_next;
	logic [ADDR_W-1:0] base_reg, base_next, addr_reg, addr_next;
	logic [WORD_W-1:0] ctrl_reg, ctrl_next, cmd1_reg, cmd1_next, cmd2_reg, cmd2_next;
	logic [WORD_W-1:0] txw_reg, txw_next, rxw_reg, rxw_next, sts_reg, sts_next;
	logic [CNT_W-1:0]  txl_reg, txl_next, nrx_reg, nrx_next, idx_reg, idx_next;
	logic [2*CNT_W-1:0] cur_plan;
	logic              mem_fire, tx_fire, rx_fire;

	word_stream_if #(.W(WORD_W)) rx_in ();
	word_stream_if #(.W(WORD_W)) rx_out ();

	// bus words are buffered so a slow memory port back-pressures the link
	word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clock (clock),
		.rst_n (rst_n),
		.en    (en),
		.in_s  (rx_in.sink),
		.out_s (rx_out.source)
	);

	assign rx_in.valid  = rx_valid;
	assign rx_in.data   = rx_data;
	assign rx_ready     = rx_in.ready;
	assign rx_out.ready = en && (state_reg == ST_TAKE_RX);
	assign rx_fire      = rx_out.valid && rx_out.ready;

	// handshakes are ignored while the clock enable is low
	assign mem_req   = en && (state_reg inside {ST_RD_CTRL, ST_RD_CMD1, ST_RD_CMD2,
		ST_RD_DATA, ST_WR_RX});
	assign mem_we    = (state_reg == ST_WR_RX);
	assign mem_fire  = mem_req && mem_ack;
	assign tx_valid  = en && (state_reg inside {ST_SEND_CMD1, ST_SEND_CMD2, ST_SEND_DATA});
	assign tx_fire   = tx_valid && tx_ready;
	assign tx_is_cmd = (state_reg != ST_SEND_DATA);
	assign mem_addr  = addr_reg;
	assign mem_wdata = rxw_reg;
	assign tx_data   = txw_reg;
	assign busy      = (state_reg != ST_IDLE);
	assign done      = (state_reg == ST_DONE);
	assign cur_plan  = plan(ctrl_reg, cmd1_reg);

	// control and command field views
	assign ctrl_bus_a      = ctrl_reg[CTL_BUS_A_BIT];
	assign ctrl_self_test  = ctrl_reg[CTL_TEST_BIT];
	assign ctrl_mask_bcast = ctrl_reg[CTL_MBC_BIT];
	assign cmd_rt_addr     = cmd1_reg[CMD_RT_MSB:CMD_RT_LSB];
	assign cmd_tr          = cmd1_reg[CMD_TR_BIT];
	assign cmd_subaddr     = cmd1_reg[CMD_SA_MSB:CMD_SA_LSB];
	assign cmd_count       = cmd1_reg[CMD_WC_MSB:CMD_WC_LSB];

	// last stored status word, decoded
	assign sts_rt_addr     = sts_reg[STS_RT_MSB:STS_RT_LSB];
	assign sts_msg_error   = sts_reg[STS_ME_BIT];
	assign sts_instr       = sts_reg[STS_IN_BIT];
	assign sts_srv_req     = sts_reg[STS_SR_BIT];
	assign sts_reserved    = sts_reg[STS_RSV_MSB:STS_RSV_LSB];
	assign sts_bcast_rcvd  = sts_reg[STS_BC_BIT];
	assign sts_busy        = sts_reg[STS_BY_BIT];
	assign sts_subsys_flag = sts_reg[STS_SF_BIT];
	assign sts_dyn_bus_acc = sts_reg[STS_DB_BIT];
	assign sts_term_flag   = sts_reg[STS_TF_BIT];

	// sequencing: one walk through the block, address advancing per word
	always_comb
	begin
		state_next = state_reg;
		base_next  = base_reg;
		addr_next  = addr_reg;
		ctrl_next  = ctrl_reg;
		cmd1_next  = cmd1_reg;
		cmd2_next  = cmd2_reg;
		txw_next   = txw_reg;
		rxw_next   = rxw_reg;
		sts_next   = sts_reg;
		txl_next   = txl_reg;
		nrx_next   = nrx_reg;
		idx_next   = idx_reg;
		unique case (state_reg)
			ST_IDLE:
				if (start)
				begin
					base_next  = block_addr;
					addr_next  = block_addr + OFS_CTRL;
					state_next = ST_RD_CTRL;
				end
			ST_RD_CTRL:
				if (mem_fire)
				begin
					// without the expanded option unused bits are dropped so they cannot steer anything
					ctrl_next  = expanded_ctrl ? mem_rdata : (mem_rdata & CTL_LEGACY_MASK);
					addr_next  = addr_reg + 16'h0001;
					state_next = ST_RD_CMD1;
				end
			ST_RD_CMD1:
				if (mem_fire)
				begin
					cmd1_next  = mem_rdata;
					txw_next   = mem_rdata;
					addr_next  = addr_reg + 16'h0001;
					state_next = ctrl_reg[CTL_RTRT_BIT] ? ST_RD_CMD2 : ST_SEND_CMD1;
				end
			ST_RD_CMD2:
				if (mem_fire)
				begin
					cmd2_next  = mem_rdata;
					txw_next   = cmd1_reg;
					addr_next  = addr_reg + 16'h0001;
					state_next = ST_SEND_CMD1;
				end
			ST_SEND_CMD1:
				if (tx_fire)
				begin
					txl_next = cur_plan[2*CNT_W-1:CNT_W];
					nrx_next = cur_plan[CNT_W-1:0];
					idx_next = CNT_RST;
					txw_next = cmd2_reg;
					if (ctrl_reg[CTL_RTRT_BIT])
						state_next = ST_SEND_CMD2;
					else if (cur_plan[2*CNT_W-1:CNT_W] != CNT_RST)
						state_next = ST_RD_DATA;
					else
						state_next = ST_TAKE_RX;
				end
			ST_SEND_CMD2:
				if (tx_fire)
					state_next = ST_TAKE_RX;
			ST_RD_DATA:
				if (mem_fire)
				begin
					txw_next   = mem_rdata;
					addr_next  = addr_reg + 16'h0001;
					state_next = ST_SEND_DATA;
				end
			ST_SEND_DATA:
				if (tx_fire)
				begin
					txl_next   = txl_reg - 6'h01;
					state_next = (txl_reg == 6'h01) ? ST_TAKE_RX : ST_RD_DATA;
				end
			ST_TAKE_RX:
				if (rx_fire)
				begin
					rxw_next   = rx_out.data;
					state_next = ST_WR_RX;
				end
			ST_WR_RX:
				if (mem_fire)
				begin
					if (is_status(ctrl_reg, idx_reg, nrx_reg))
						sts_next = rxw_reg;
					addr_next  = addr_reg + 16'h0001;
					idx_next   = idx_reg + 6'h01;
					state_next = (idx_reg + 6'h01 == nrx_reg) ? ST_DONE : ST_TAKE_RX;
				end
			ST_DONE:
				state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_IDLE;
			base_reg  <= '0;
			addr_reg  <= '0;
			ctrl_reg  <= WORD_RST;
			cmd1_reg  <= WORD_RST;
			cmd2_reg  <= WORD_RST;
			txw_reg   <= WORD_RST;
			rxw_reg   <= WORD_RST;
			sts_reg   <= WORD_RST;
			txl_reg   <= CNT_RST;
			nrx_reg   <= CNT_RST;
			idx_reg   <= CNT_RST;
		end
		else if (en)
		begin
			state_reg <= state_next;
			base_reg  <= base_next;
			addr_reg  <= addr_next;
			ctrl_reg  <= ctrl_next;
			cmd1_reg  <= cmd1_next;
			cmd2_reg  <= cmd2_next;
			txw_reg   <= txw_next;
			rxw_reg   <= rxw_next;
			sts_reg   <= sts_next;
			txl_reg   <= txl_next;
			nrx_reg   <= nrx_next;
			idx_reg   <= idx_next;
		end
	end

	// checks on the block walk
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_ctrl_at_base: assert property (
		(state_reg == ST_RD_CTRL) |-> (mem_addr == base_reg + OFS_CTRL))
		else $error("control word not fetched from block offset zero");
	a_cmd_order: assert property (
		(state_reg == ST_RD_CMD1) |-> (mem_addr == base_reg + OFS_CMD1) && !mem_we)
		else $error("first command not fetched right after control word");
	a_rx_contig: assert property (
		(en && mem_fire && mem_we) |=> (addr_reg == $past(addr_reg) + 16'h0001))
		else $error("received words not stored contiguously");
	a_no_ctrl_tx: assert property (
		(state_reg == ST_RD_CMD1) && en && mem_fire |=> !tx_valid || tx_data != ctrl_reg
			|| ctrl_reg == cmd1_reg)
		else $error("control word placed on the bus");
	a_legacy_mask: assert property (
		(state_reg == ST_RD_CTRL) && en && mem_fire && !expanded_ctrl
			|=> (ctrl_reg & ~CTL_LEGACY_MASK) == WORD_RST)
		else $error("unused control bits kept without expanded option");
	a_rt_bc_layout: assert property (
		(state_reg == ST_SEND_CMD1) && tx_fire && en && ctrl_reg[2:0] == 3'h0
			&& cmd1_reg[CMD_TR_BIT]
			|=> (state_reg == ST_TAKE_RX) && (nrx_reg == word_count(cmd1_reg) + 6'h02))
		else $error("terminal-to-controller block sized wrong");
	a_bc_rt_layout: assert property (
		(state_reg == ST_SEND_CMD1) && tx_fire && en && ctrl_reg[2:0] == 3'h0
			&& !cmd1_reg[CMD_TR_BIT]
			|=> (txl_reg == word_count(cmd1_reg)) && (nrx_reg == 6'h02))
		else $error("controller-to-terminal block sized wrong");
	a_mode_layout: assert property (
		(state_reg == ST_SEND_CMD1) && tx_fire && en && ctrl_reg[CTL_MODE_BIT]
			&& ctrl_reg[CTL_BCAST_BIT] |=> (nrx_reg == 6'h01))
		else $error("broadcast mode block must hold only the loopback");
	a_status_take: assert property (
		(state_reg == ST_WR_RX) && en && mem_fire && idx_reg == 6'h01
			&& !ctrl_reg[CTL_BCAST_BIT] |=> (sts_rt_addr == $past(rxw_reg[15:11])))
		else $error("status word address field not decoded");
	a_cmd_sent: assert property (
		(state_reg == ST_SEND_CMD1) && !ctrl_reg[CTL_RTRT_BIT]
			|-> (tx_data[15:11] == cmd_rt_addr) && tx_is_cmd)
		else $error("command on bus differs from fetched command");
	// a frozen clock enable legitimately stretches the done state
	a_done_pulse: assert property (
		done && en |=> !done)
		else $error("done held longer than one cycle");

	c_rt_rt: cover property (done && ctrl_reg[CTL_RTRT_BIT] && !ctrl_reg[CTL_BCAST_BIT]);
	c_mode_data: cover property (done && ctrl_reg[CTL_MODE_BIT] && cmd1_reg[MODE_DATA_BIT]);
	c_bcast: cover property (done && ctrl_reg[CTL_BCAST_BIT] && !ctrl_reg[CTL_MODE_BIT]);
	c_fifo_full: cover property (rx_valid && !rx_ready);
endmodule : bc_message_block_sequencer

// ### dv/bc_far_side_model.sv
// shared ram and bus terminal model facing the sequencer
module bc_far_side_model
	import bc_seq_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              slow,
	input  wire logic              mem_req,
	input  wire logic              mem_we,
	input  wire logic [ADDR_W-1:0] mem_addr,
	input  wire logic [WORD_W-1:0] mem_wdata,
	output logic                   mem_ack,
	output logic      [WORD_W-1:0] mem_rdata,
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	input  wire logic [WORD_W-1:0] tx_data,
	input  wire logic              tx_is_cmd,
	output logic                   rx_valid,
	input  wire logic              rx_ready,
	output logic      [WORD_W-1:0] rx_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WORD_W-1:0] mem [0:255];
	logic [WORD_W-1:0] rx_q [$];
	logic [WORD_W-1:0] rd_log [$];
	logic [WORD_W:0]   tx_log [$];
	logic [2:0]        tick = 3'h0;
	// slow mode answers one cycle in four, so waits are really exercised
	assign mem_ack = mem_req && (!slow || tick[1:0] == 2'h3);
	// cycles without an answer show the inverse, so stale data cannot pass
	assign mem_rdata = (mem_ack && !mem_we) ? mem[mem_addr[7:0]] : ~mem[mem_addr[7:0]];
	assign tx_ready = !slow || tick[0];
	initial rx_valid = 1'b0;
	initial rx_data = 16'h0000;
	// ram writes, access logs and delivery of terminal responses
	always @(posedge clock)
	begin
		tick <= tick + 3'h1;
		if (mem_ack && mem_we)
			mem[mem_addr[7:0]] <= mem_wdata;
		if (mem_ack && !mem_we)
			rd_log.push_back(mem_addr);
		if (tx_valid && tx_ready)
			tx_log.push_back({tx_is_cmd, tx_data});
		if (!rx_valid || rx_ready)
		begin
			if (rx_q.size() > 0 && !(slow && tick[1]))
			begin
				rx_valid <= 1'b1;
				rx_data  <= rx_q.pop_front();
			end
			else
			begin
				rx_valid <= 1'b0;
				rx_data  <= ~rx_data;
			end
		end
	end
endmodule : bc_far_side_model

// ### dv/bc_message_block_sequencer_test.sv
// self-checking bench for the message block sequencer
module bc_message_block_sequencer_test
	import bc_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_n, en, expanded_ctrl, start, slow;
	logic [ADDR_W-1:0] block_addr, mem_addr;
	logic [WORD_W-1:0] mem_wdata, mem_rdata, tx_data, rx_data;
	logic busy, done, mem_req, mem_we, mem_ack, tx_valid, tx_ready, tx_is_cmd;
	logic rx_valid, rx_ready, ctrl_bus_a, ctrl_self_test, ctrl_mask_bcast, cmd_tr;
	logic [4:0] cmd_rt_addr, cmd_subaddr, cmd_count, sts_rt_addr;
	logic sts_msg_error, sts_instr, sts_srv_req, sts_bcast_rcvd, sts_busy;
	logic sts_subsys_flag, sts_dyn_bus_acc, sts_term_flag;
	logic [2:0] sts_reserved;
	int error_cnt = 0;
	int check_count = 0;

	bc_message_block_sequencer DUT (.clock, .rst_n, .en, .expanded_ctrl, .start,
		.block_addr, .busy, .done, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
		.mem_rdata, .tx_valid, .tx_ready, .tx_data, .tx_is_cmd, .rx_valid, .rx_ready,
		.rx_data, .ctrl_bus_a, .ctrl_self_test, .ctrl_mask_bcast, .cmd_rt_addr, .cmd_tr,
		.cmd_subaddr, .cmd_count, .sts_rt_addr, .sts_msg_error, .sts_instr, .sts_srv_req,
		.sts_reserved, .sts_bcast_rcvd, .sts_busy, .sts_subsys_flag, .sts_dyn_bus_acc,
		.sts_term_flag);

	bc_far_side_model model (.clock, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_ack, .mem_rdata, .tx_valid, .tx_ready, .tx_data, .tx_is_cmd, .rx_valid,
		.rx_ready, .rx_data);

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// terminal response i: loopback, then status at index 1 and at the end of rt-rt
	function automatic logic [WORD_W-1:0] rx_word(input int i, input int nrx,
		input int rtrt, input logic [WORD_W-1:0] sts);
		return (i == 1 || (rtrt != 0 && i == nrx - 1)) ? sts : 16'hb000 + 16'(i);
	endfunction : rx_word

	// host loads a block, the terminal answers, then the whole block is judged
	task automatic run_msg(input string name, input int base, input logic [15:0] ctrl,
		input logic [15:0] c1, input logic [15:0] c2, input int ntx, input int nrx,
		input int rtrt, input logic [15:0] sts);
		int h;
		int n;
		logic [16:0] exp_tx;
		h = 2 + rtrt + ntx;
		model.mem[base] = ctrl;
		model.mem[base + 1] = c1;
		model.mem[base + 2] = c2;
		for (int i = 0; i < ntx; i++)
			model.mem[base + 2 + rtrt + i] = 16'hd000 + 16'(i);
		for (int i = 0; i <= nrx; i++)
			model.mem[base + h + i] = 16'hffff;
		model.rd_log.delete();
		model.tx_log.delete();
		for (int i = 0; i < nrx; i++)
			model.rx_q.push_back(rx_word(i, nrx, rtrt, sts));
		@(posedge clock);
		block_addr <= 16'(base);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		#1;
		check(busy, 1'b1);
		n = 0;
		while (done !== 1'b1 && n < 3000)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		check(done, 1'b1);
		check(model.rd_log.size(), h);
		for (int i = 0; i < model.rd_log.size(); i++)
			check(model.rd_log[i], base + i);
		check(model.tx_log.size(), 1 + rtrt + ntx);
		for (int i = 0; i < model.tx_log.size(); i++)
		begin
			exp_tx = {1'b0, 16'hd000 + 16'(i - 1 - rtrt)};
			if (i < 1 + rtrt)
				exp_tx = {1'b1, (i == 0) ? c1 : c2};
			check(model.tx_log[i], exp_tx);
		end
		for (int i = 0; i <= nrx; i++)
			check(model.mem[base + h + i], i == nrx ? 16'hffff : rx_word(i, nrx, rtrt, sts));
		check({cmd_rt_addr, cmd_tr, cmd_subaddr, cmd_count}, c1);
		if (nrx > 1)
			check({sts_rt_addr, sts_msg_error, sts_instr, sts_srv_req, sts_reserved,
				sts_bcast_rcvd, sts_busy, sts_subsys_flag, sts_dyn_bus_acc, sts_term_flag}, sts);
		check({ctrl_bus_a, ctrl_self_test, ctrl_mask_bcast}, ctrl[7:5]);
		check(DUT.ctrl_reg, expanded_ctrl ? ctrl : ctrl & 16'h00e7);
		$display("test %s done", name);
	endtask : run_msg

	// controller to terminal, two data words
	task automatic t_bc_to_rt;
		run_msg("bc_to_rt", 16, 16'h00a0, 16'h1822, 16'h0000, 2, 2, 0, 16'h5a5b);
	endtask : t_bc_to_rt

	// terminal to controller, count 0 means 32 words; slow far side fills the fifo
	task automatic t_rt_to_bc;
		slow <= 1'b1;
		run_msg("rt_to_bc", 32, 16'h0040, 16'h3c40, 16'h0000, 0, 34, 0, 16'h3a05);
		slow <= 1'b0;
	endtask : t_rt_to_bc

	// terminal to terminal, two data words between two status words
	task automatic t_rt_to_rt;
		run_msg("rt_to_rt", 112, 16'h0001, 16'h20a2, 16'h4cc2, 0, 5, 1, 16'h2708);
	endtask : t_rt_to_rt

	// mode command without data
	task automatic t_mode;
		run_msg("mode", 144, 16'h0004, 16'h0c02, 16'h0000, 0, 2, 0, 16'h0811);
	endtask : t_mode

	// broadcast: loopback only, no status comes back
	task automatic t_bcast;
		run_msg("bcast", 160, 16'h0002, 16'hf821, 16'h0000, 1, 1, 0, 16'h0000);
	endtask : t_bcast

	// upper control bits set but ignored without the expanded option
	task automatic t_legacy_ctrl;
		expanded_ctrl <= 1'b0;
		run_msg("legacy_ctrl", 176, 16'hffe0, 16'h1061, 16'h0000, 1, 2, 0, 16'h1000);
		expanded_ctrl <= 1'b1;
	endtask : t_legacy_ctrl

	// clock enable dropped mid-message: handshakes must go quiet, walk resumes intact
	task automatic t_freeze;
		fork
			run_msg("freeze", 192, 16'h0080, 16'h0841, 16'h0000, 1, 2, 0, 16'h0800);
			begin
				repeat (4) @(posedge clock);
				en <= 1'b0;
				repeat (3) @(posedge clock);
				#1;
				check({mem_req, tx_valid, rx_ready}, 3'h0);
				@(posedge clock);
				en <= 1'b1;
			end
		join
	endtask : t_freeze

	// free running clock, 8 ns period
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// main sequence
	initial
	begin
		rst_n = 1'b0;
		en = 1'b1;
		expanded_ctrl = 1'b1;
		start = 1'b0;
		slow = 1'b0;
		block_addr = 16'h0000;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		t_bc_to_rt();
		t_rt_to_bc();
		t_rt_to_rt();
		t_mode();
		t_bcast();
		t_legacy_ctrl();
		t_freeze();
		results();
	end

	// the whole run needs well under 2000 cycles; this cuts a hang short
	initial
	begin
		repeat (40000) @(posedge clock);
		error_cnt++;
		results();
	end
endmodule : bc_message_block_sequencer_test
